// *** src/rstx_top.sv ***
// Purpose: Transmit path of a radio serial port: FIFO, line coder, baud timing.
// Assumes: Byte register port; bus inputs synchronous to clock_i.
// Notes:   Encoder and pin stage are decoupled by a two-entry symbol buffer.
//
// Overview of operation
// - Transmit only when tx enabled, rx disabled.
// - Four-byte FIFO; interrupt when it empties.
// - NRZ space: zero byte sends 01010101.
// - Code select 111 chooses Miller coding.
// - Miller symbol rate is twice bit rate.
// - Symbol rate is clock over 16*coarse*fine.
// - External clock select 0 ignores bit clock.
// - Encoder off shifts bytes out uncoded.
// - Encoder enable latched when byte enters shifter.
// - Interrupt on last byte fetch; refill meanwhile.
// - Pins: rx data, bit clock, pattern, tx.
// - Code select 010 chooses NRZ space.
// - Coarse 00 gives 1, 01 gives 4.
`timescale 1ns/1ps
module rstx_top
	import rstx_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            tx_irq_o,
	input  wire logic       radio_pin_rx_data_i,
	input  wire logic       radio_pin_bit_clock_i,
	input  wire logic       radio_pin_pattern_detect_i,
	output logic            radio_pin_tx_data_o
);
	// ****************************************************************
	// Register port
	// ****************************************************************
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] baud_q, baud_d;
	logic [7:0] rdata_q, rdata_d;
	logic       tx_active;
	logic [2:0] fifo_cnt_q, fifo_cnt_d;
	logic       busy;

	always_comb begin
		ctrl_d  = ctrl_q;
		baud_d  = baud_q;
		rdata_d = 8'h00;
		if (wr_i && addr_i == RSTX_ADDR_CTRL) begin
			ctrl_d = wdata_i;
		end
		if (wr_i && addr_i == RSTX_ADDR_BAUD) begin
			baud_d = wdata_i;
		end
		if (rd_i) begin
			unique case (addr_i)
				RSTX_ADDR_CTRL: begin
					rdata_d = ctrl_q;
				end
				RSTX_ADDR_BAUD: begin
					rdata_d = baud_q;
				end
				RSTX_ADDR_STATUS: begin
					rdata_d[RSTX_STAT_CNT_HI:RSTX_STAT_CNT_LO] = fifo_cnt_q;
					rdata_d[RSTX_STAT_FULL]    = (fifo_cnt_q == RSTX_FIFO_FULL);
					rdata_d[RSTX_STAT_EMPTY]   = (fifo_cnt_q == 3'h0);
					rdata_d[RSTX_STAT_BUSY]    = busy;
					rdata_d[RSTX_STAT_PATTERN] = radio_pin_pattern_detect_i;
					rdata_d[RSTX_STAT_RXD]     = radio_pin_rx_data_i;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q  <= RSTX_CTRL_RESET;
			baud_q  <= RSTX_BAUD_RESET;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q  <= ctrl_d;
			baud_q  <= baud_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o   = rdata_q;
	assign tx_active = ctrl_q[RSTX_CTRL_TX_EN] && !ctrl_q[RSTX_CTRL_RX_EN];

	// ****************************************************************
	// Baud timing
	// ****************************************************************
	logic [13:0] div_q, div_d;
	logic        bclk_q, bclk_d;
	logic        tick;

	always_comb begin
		div_d  = div_q;
		bclk_d = radio_pin_bit_clock_i;
		if (!tx_active) begin
			div_d = 14'h0000;
		end else if (div_q == 14'h0000) begin
			div_d = rstx_period(baud_q[RSTX_BAUD_COARSE_HI:RSTX_BAUD_COARSE_LO],
				baud_q[RSTX_BAUD_FINE_HI:RSTX_BAUD_FINE_LO]) - 14'h0001;
		end else begin
			div_d = div_q - 14'h0001;
		end
		if (ctrl_q[RSTX_CTRL_EXT_CLK]) begin
			tick = tx_active && radio_pin_bit_clock_i && !bclk_q;
		end else begin
			tick = tx_active && (div_q == 14'h0000);
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_q  <= 14'h0000;
			bclk_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			bclk_q <= bclk_d;
		end
	end

	// ****************************************************************
	// Transmit FIFO
	// ****************************************************************
	logic [7:0] fifo_mem_q [RSTX_FIFO_DEPTH];
	logic [1:0] wp_q, wp_d;
	logic [1:0] rp_q, rp_d;
	logic       fifo_push, fifo_pop;

	always_comb begin
		fifo_push  = wr_i && addr_i == RSTX_ADDR_TXDATA && fifo_cnt_q != RSTX_FIFO_FULL;
		wp_d       = fifo_push ? wp_q + 2'h1 : wp_q;
		rp_d       = fifo_pop ? rp_q + 2'h1 : rp_q;
		fifo_cnt_d = fifo_cnt_q;
		if (fifo_push && !fifo_pop) begin
			fifo_cnt_d = fifo_cnt_q + 3'h1;
		end else if (fifo_pop && !fifo_push) begin
			fifo_cnt_d = fifo_cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_q       <= 2'h0;
			rp_q       <= 2'h0;
			fifo_cnt_q <= 3'h0;
			for (int i = 0; i < RSTX_FIFO_DEPTH; i++) begin
				fifo_mem_q[i] <= 8'h00;
			end
		end else begin
			wp_q       <= wp_d;
			rp_q       <= rp_d;
			fifo_cnt_q <= fifo_cnt_d;
			if (fifo_push) begin
				fifo_mem_q[wp_q] <= wdata_i;
			end
		end
	end

	// ****************************************************************
	// Shift register and line coder
	// ****************************************************************
	typedef enum logic {RSTX_ST_IDLE, RSTX_ST_SHIFT} rstx_state_t;

	rstx_sym_if sym ();

	rstx_state_t st_q, st_d;
	logic [7:0]  sh_q, sh_d;
	logic [2:0]  bit_q, bit_d;
	logic        half_q, half_d;
	logic        coded_q, coded_d;
	rstx_code_t  code_q, code_d;
	logic        last_q, last_d;
	logic        prev_q, prev_d;
	logic        irq_q, irq_d;
	logic        b, s, two, push, fetch;

	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		bit_d   = bit_q;
		half_d  = half_q;
		coded_d = coded_q;
		code_d  = code_q;
		last_d  = last_q;
		prev_d  = prev_q;
		irq_d   = 1'b0;
		b       = sh_q[7];
		s       = b;
		two     = 1'b0;
		fetch   = 1'b0;
		if (coded_q) begin
			unique case (code_q)
				RSTX_CODE_NRZ_MARK: begin
					s = last_q ^ b;
				end
				RSTX_CODE_NRZ_SPACE: begin
					s = last_q ^ ~b;
				end
				RSTX_CODE_MANCH: begin
					two = 1'b1;
					s   = half_q ? ~b : b;
				end
				RSTX_CODE_MILLER: begin
					// Two symbols per bit, so the divider sets the symbol rate.
					two = 1'b1;
					if (!half_q) begin
						s = (!b && !prev_q) ? ~last_q : last_q;
					end else begin
						s = b ? ~last_q : last_q;
					end
				end
				default: begin
					s = b;
				end
			endcase
		end
		push = (st_q == RSTX_ST_SHIFT) && sym.in_ready;
		if (push) begin
			last_d = s;
			if (two && !half_q) begin
				half_d = 1'b1;
			end else begin
				half_d = 1'b0;
				prev_d = b;
				sh_d   = {sh_q[6:0], 1'b0};
				bit_d  = bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					st_d = RSTX_ST_IDLE;
					// The next byte is taken at once so no gap appears on the line.
					fetch = tx_active && fifo_cnt_q != 3'h0;
				end
			end
		end else if (st_q == RSTX_ST_IDLE) begin
			fetch = tx_active && fifo_cnt_q != 3'h0;
		end
		if (fetch) begin
			st_d    = RSTX_ST_SHIFT;
			sh_d    = fifo_mem_q[rp_q];
			bit_d   = 3'h0;
			half_d  = 1'b0;
			coded_d = ctrl_q[RSTX_CTRL_CODER_EN];
			code_d  = rstx_code_t'(ctrl_q[RSTX_CTRL_CODE_HI:RSTX_CTRL_CODE_LO]);
			irq_d   = (fifo_cnt_q == 3'h1) && !fifo_push;
		end
		fifo_pop = fetch;
		busy     = (st_q == RSTX_ST_SHIFT) || sym.out_valid;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q    <= RSTX_ST_IDLE;
			sh_q    <= 8'h00;
			bit_q   <= 3'h0;
			half_q  <= 1'b0;
			coded_q <= 1'b0;
			code_q  <= RSTX_CODE_NRZ_LEVEL;
			last_q  <= RSTX_LINE_RESET;
			prev_q  <= 1'b1;
			irq_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			sh_q    <= sh_d;
			bit_q   <= bit_d;
			half_q  <= half_d;
			coded_q <= coded_d;
			code_q  <= code_d;
			last_q  <= last_d;
			prev_q  <= prev_d;
			irq_q   <= irq_d;
		end
	end

	assign tx_irq_o     = irq_q;
	assign sym.in_valid = (st_q == RSTX_ST_SHIFT);
	assign sym.in_data  = s;

	// ****************************************************************
	// Symbol buffer and pin stage
	// ****************************************************************
	logic pin_q, pin_d;

	rstx_sym_buf u_buf (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.sym     (sym.buffer)
	);

	always_comb begin
		pin_d = pin_q;
		if (tick && sym.out_valid) begin
			pin_d = sym.out_data;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_q <= RSTX_LINE_RESET;
		end else begin
			pin_q <= pin_d;
		end
	end

	assign sym.out_ready        = tick;
	assign radio_pin_tx_data_o  = pin_q;

endmodule : rstx_top

// *** src/rstx_pkg.sv ***
// Purpose: Shared constants and types of the radio serial transmit path.
// Assumes: Byte-wide register port, 3-bit register address.
// Notes:   Line-code select values and divider mapping are kept here once.
package rstx_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [2:0] RSTX_ADDR_CTRL   = 3'h0;
	localparam logic [2:0] RSTX_ADDR_BAUD   = 3'h1;
	localparam logic [2:0] RSTX_ADDR_TXDATA = 3'h2;
	localparam logic [2:0] RSTX_ADDR_STATUS = 3'h3;

	// Control register fields.
	localparam int RSTX_CTRL_TX_EN    = 0;
	localparam int RSTX_CTRL_RX_EN    = 1;
	localparam int RSTX_CTRL_EXT_CLK  = 2;
	localparam int RSTX_CTRL_CODER_EN = 3;
	localparam int RSTX_CTRL_CODE_LO  = 4;
	localparam int RSTX_CTRL_CODE_HI  = 6;
	localparam logic [7:0] RSTX_CTRL_RESET = 8'h00;

	// Baud register fields.
	localparam int RSTX_BAUD_FINE_LO   = 0;
	localparam int RSTX_BAUD_FINE_HI   = 3;
	localparam int RSTX_BAUD_COARSE_LO = 4;
	localparam int RSTX_BAUD_COARSE_HI = 5;
	localparam logic [7:0] RSTX_BAUD_RESET = 8'h00;

	// Status register fields.
	localparam int RSTX_STAT_CNT_LO  = 0;
	localparam int RSTX_STAT_CNT_HI  = 2;
	localparam int RSTX_STAT_FULL    = 3;
	localparam int RSTX_STAT_EMPTY   = 4;
	localparam int RSTX_STAT_BUSY    = 5;
	localparam int RSTX_STAT_PATTERN = 6;
	localparam int RSTX_STAT_RXD     = 7;

	// ****************************************************************
	// Sizes and timing
	// ****************************************************************
	localparam int          RSTX_FIFO_DEPTH = 4;
	localparam logic [2:0]  RSTX_FIFO_FULL  = 3'h4;
	localparam logic [13:0] RSTX_DIV_BASE   = 14'h0010;
	localparam logic        RSTX_LINE_RESET = 1'b1;

	// ****************************************************************
	// Line codes
	// ****************************************************************
	typedef enum logic [2:0] {
		RSTX_CODE_NRZ_LEVEL = 3'h0,
		RSTX_CODE_NRZ_MARK  = 3'h1,
		RSTX_CODE_NRZ_SPACE = 3'h2,
		RSTX_CODE_MANCH     = 3'h3,
		RSTX_CODE_MILLER    = 3'h7
	} rstx_code_t;

	// Symbol period in clocks: 16 times coarse factor times fine factor.
	function automatic logic [13:0] rstx_period(input logic [1:0] coarse,
		input logic [3:0] fine);
		logic [13:0] c;
		c = 14'h0001 << {coarse, 1'b0};
		rstx_period = 14'((c * ({10'h000, fine} + 14'h0001)) << 4);
	endfunction : rstx_period

endpackage : rstx_pkg

// *** src/rstx_sym_if.sv ***
// Purpose: Symbol stream between the encoder and the output buffer.
// Assumes: One clock domain.
// Notes:   Valid/ready on both sides of the buffer.
`timescale 1ns/1ps
interface rstx_sym_if;
	logic in_valid;
	logic in_ready;
	logic in_data;
	logic out_valid;
	logic out_ready;
	logic out_data;

	modport buffer (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface : rstx_sym_if

// *** src/rstx_sym_buf.sv ***
// Purpose: Two-entry symbol buffer with valid and ready on both sides.
// Assumes: Synchronous single-clock use.
// Notes:   Ready depends only on the fill count, so no path runs through it.
`timescale 1ns/1ps
module rstx_sym_buf
	import rstx_pkg::*;
(
	input  wire logic   clock_i,
	input  wire logic   nrst_i,
	rstx_sym_if.buffer  sym
);
	logic [1:0] cnt_q, cnt_d;
	logic       e0_q, e0_d;
	logic       e1_q, e1_d;
	logic       push, pop;

	always_comb begin
		push  = sym.in_valid && (cnt_q != 2'h2);
		pop   = sym.out_ready && (cnt_q != 2'h0);
		cnt_d = cnt_q;
		e0_d  = e0_q;
		e1_d  = e1_q;
		if (pop) begin
			e0_d = e1_q;
		end
		if (push) begin
			if ((cnt_q == 2'h0) || (cnt_q == 2'h1 && pop)) begin
				e0_d = sym.in_data;
			end else begin
				e1_d = sym.in_data;
			end
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= 2'h0;
			e0_q  <= 1'b0;
			e1_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			e0_q  <= e0_d;
			e1_q  <= e1_d;
		end
	end

	assign sym.in_ready  = (cnt_q != 2'h2);
	assign sym.out_valid = (cnt_q != 2'h0);
	assign sym.out_data  = e0_q;

endmodule : rstx_sym_buf

// *** dv/rstx_checker.sv ***
// Purpose: Port-level assertions for the radio serial transmit path.
// Assumes: One clock domain; register writes are decoded here as the block does.
// Notes:   Config writes suspend the width check, since the divider does not reload then.
`timescale 1ns/1ps
module rstx_checker
	import rstx_pkg::*;
(
	input wire logic       clock_i,
	input wire logic       nrst_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       tx_irq_o,
	input wire logic       radio_pin_rx_data_i,
	input wire logic       radio_pin_bit_clock_i,
	input wire logic       radio_pin_pattern_detect_i,
	input wire logic       radio_pin_tx_data_o
);
	// ********************
	// Shadow state
	// ********************
	logic        en_q;
	logic        ext_q;
	logic        wrote_q;
	logic        pin_q;
	logic [15:0] per_q;
	logic [15:0] gap_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_q    <= 1'b0;
			ext_q   <= 1'b0;
			wrote_q <= 1'b0;
			pin_q   <= 1'b1;
			per_q   <= 16'h0010;
			gap_q   <= 16'hFFFF;
		end else begin
			pin_q <= radio_pin_tx_data_o;
			if (wr_i && addr_i == RSTX_ADDR_CTRL) begin
				en_q  <= wdata_i[0] & ~wdata_i[1];
				ext_q <= wdata_i[2];
			end
			if (wr_i && addr_i == RSTX_ADDR_BAUD) begin
				per_q <= ({12'h000, wdata_i[3:0]} + 16'h0001) << (4 + 2 * wdata_i[5:4]);
			end
			if (wr_i && addr_i == RSTX_ADDR_TXDATA) begin
				wrote_q <= 1'b1;
			end
			if (wr_i && (addr_i == RSTX_ADDR_CTRL || addr_i == RSTX_ADDR_BAUD)) begin
				gap_q <= 16'hFFFF;
			end else if (pin_q != radio_pin_tx_data_o) begin
				gap_q <= 16'h0000;
			end else if (gap_q != 16'hFFFF) begin
				gap_q <= gap_q + 16'h0001;
			end
		end
	end

	// ********************
	// Properties
	// ********************
	sequence s_quiet8;
		!tx_irq_o [*8];
	endsequence

	a_irq_lone_pulse: assert property (tx_irq_o |=> s_quiet8)
		else $error("transmit interrupt is not a lone pulse");
	a_idle_no_irq: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |-> !tx_irq_o)
		else $error("interrupt while the transmitter is inactive");
	a_idle_pin_hold: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
		|-> $stable(radio_pin_tx_data_o))
		else $error("transmit pin moved while inactive");
	a_symbol_min_gap: assert property (!ext_q && pin_q != radio_pin_tx_data_o
		|-> gap_q >= per_q - 16'h0001)
		else $error("transmit symbol shorter than the baud period");
	a_status_pin_view: assert property (rd_i && addr_i == RSTX_ADDR_STATUS
		|=> rdata_o[7:6] == $past({radio_pin_rx_data_i, radio_pin_pattern_detect_i}))
		else $error("status does not show the input pins");
	a_pin_reset_idle: assert property (!$past(nrst_i) |-> radio_pin_tx_data_o)
		else $error("transmit pin not idle after reset");
	a_quiet_before_data: assert property (!wrote_q |-> radio_pin_tx_data_o && !tx_irq_o)
		else $error("activity before any byte was written");
	a_read_data_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside the answer cycle");
endmodule : rstx_checker

bind rstx_top rstx_checker rstx_checker_inst (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .tx_irq_o, .radio_pin_rx_data_i, .radio_pin_bit_clock_i,
	.radio_pin_pattern_detect_i, .radio_pin_tx_data_o);

// *** dv/rstx_radio_model.sv ***
// Purpose: Transceiver stand-in that samples the transmit pin mid-symbol.
// Assumes: Fixed symbol period PER in clocks once the first edge is seen.
// Notes:   It never resyncs, so any gap between bytes shows as a shifted stream.
`timescale 1ns/1ps
module rstx_radio_model #(
	parameter int PER = 16
) (
	input  wire logic  clock_i,
	input  wire logic  nrst_i,
	input  wire logic  tx_i,
	output logic       bitclk_o,
	output logic       rxd_o,
	output logic       pat_o,
	output logic [79:0] sym_o,
	output logic [7:0] n_o
);
	logic run_q;
	logic tx_q;
	int   cnt_q;

	assign rxd_o = 1'b1;
	assign pat_o = 1'b0;

	// The bit clock keeps running so that a block which wrongly follows it is seen.
	initial begin
		bitclk_o = 1'b0;
		forever #130 bitclk_o = ~bitclk_o;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_q <= 1'b0;
			tx_q  <= 1'b1;
			cnt_q <= 0;
			sym_o <= '0;
			n_o   <= 8'h00;
		end else begin
			tx_q <= tx_i;
			if (!run_q && tx_i !== tx_q) begin
				run_q <= 1'b1;
				cnt_q <= PER / 2;
			end else if (run_q && cnt_q == 0) begin
				sym_o <= {sym_o[78:0], tx_i};
				n_o   <= n_o + 8'h01;
				cnt_q <= PER - 1;
			end else if (run_q) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
endmodule : rstx_radio_model

// *** dv/radio_serial_transmit_path_tb.sv ***
// Purpose: Register-level bench of the radio serial transmit path.
// Assumes: One stream at 16 clocks a symbol, then single-byte rate probes.
// Notes:   Expected streams are worked out by hand from the line codes.
`timescale 1ns/1ps
module radio_serial_transmit_path_tb
	import rstx_pkg::*;
();
	logic        clock_i;
	logic        nrst_i;
	logic [2:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        tx_irq_o;
	logic        radio_pin_rx_data_i;
	logic        radio_pin_bit_clock_i;
	logic        radio_pin_pattern_detect_i;
	logic        radio_pin_tx_data_o;
	logic [79:0] sym;
	logic [7:0]  nsym;
	logic [7:0]  v;
	logic [7:0]  bauds [4] = '{8'h12, 8'h10, 8'h00, 8'h00};
	logic [7:0]  ctrls [4] = '{8'h29, 8'h29, 8'h79, 8'h39};
	int          gaps [4] = '{192, 64, 32, 16};
	int          fails;
	int          n_compared;
	int          irq_n;
	int          i;
	int          g;

	rstx_top rstx_top_inst (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.tx_irq_o, .radio_pin_rx_data_i, .radio_pin_bit_clock_i,
		.radio_pin_pattern_detect_i, .radio_pin_tx_data_o);
	rstx_radio_model #(.PER(16)) rstx_radio_model_inst (.clock_i, .nrst_i,
		.tx_i(radio_pin_tx_data_o), .bitclk_o(radio_pin_bit_clock_i),
		.rxd_o(radio_pin_rx_data_i), .pat_o(radio_pin_pattern_detect_i), .sym_o(sym), .n_o(nsym));

	// ********************
	// Tasks
	// ********************
	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : bus_wr

	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		d = rdata_o;
		@(posedge clock_i);
	endtask : bus_rd

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		bus_rd(a, v);
		chk(80'(v), 80'(exp));
	endtask : rd_chk

	task automatic wait_irq;
		int k;
		k = irq_n;
		for (int j = 0; j < 3000 && irq_n == k; j++) @(posedge clock_i);
	endtask : wait_irq

	task automatic wait_idle;
		v = 8'hFF;
		for (int j = 0; j < 2000 && v[5] !== 1'b0; j++) bus_rd(RSTX_ADDR_STATUS, v);
		chk(80'(v), 80'h90);
	endtask : wait_idle

	// Spacing of the second and third pin edges, so the start offset is left out.
	task automatic edge_gap(output int gap);
		int e;
		int t0;
		logic p;
		e = 0;
		t0 = 0;
		gap = 0;
		p = radio_pin_tx_data_o;
		for (int j = 0; j < 3000 && e < 3; j++) begin
			@(posedge clock_i);
			if (radio_pin_tx_data_o !== p) e++;
			if (radio_pin_tx_data_o !== p && e == 2) t0 = j;
			if (radio_pin_tx_data_o !== p && e == 3) gap = j - t0;
			p = radio_pin_tx_data_o;
		end
	endtask : edge_gap

	task automatic print_verdict;
		$display("compared=%0d failed=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// ********************
	// Sequence
	// ********************
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	always @(posedge clock_i) if (tx_irq_o === 1'b1) irq_n <= irq_n + 1;

	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		print_verdict();
	end

	initial begin
		nrst_i = 1'b0;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		fails = 0;
		n_compared = 0;
		irq_n = 0;
		repeat (12) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		rd_chk(RSTX_ADDR_CTRL, 8'h00);
		rd_chk(RSTX_ADDR_BAUD, 8'h00);
		rd_chk(RSTX_ADDR_STATUS, 8'h90);
		rd_chk(3'h5, 8'h00);
		for (i = 0; i < 5; i++) bus_wr(RSTX_ADDR_TXDATA, (i == 4) ? 8'hFF : 8'h00);
		bus_wr(RSTX_ADDR_CTRL, 8'h2B);
		rd_chk(RSTX_ADDR_STATUS, 8'h8C);
		bus_wr(RSTX_ADDR_CTRL, 8'h29);
		wait_irq();
		bus_wr(RSTX_ADDR_CTRL, 8'h01);
		bus_wr(RSTX_ADDR_TXDATA, 8'h00);
		wait_irq();
		bus_wr(RSTX_ADDR_CTRL, 8'h09);
		bus_wr(RSTX_ADDR_TXDATA, 8'hA5);
		bus_wr(RSTX_ADDR_TXDATA, 8'h5A);
		bus_wr(RSTX_ADDR_TXDATA, 8'hC3);
		bus_wr(RSTX_ADDR_TXDATA, 8'h3C);
		rd_chk(RSTX_ADDR_STATUS, 8'hAC);
		for (i = 0; i < 4000 && nsym !== 8'd72; i++) @(posedge clock_i);
		chk(sym[71:0], 80'h55555555_00A55AC33C);
		// The last probe sends a zero byte in the two-symbol split-phase code.
		for (i = 0; i < 4; i++) begin
			wait_idle();
			bus_wr(RSTX_ADDR_BAUD, bauds[i]);
			bus_wr(RSTX_ADDR_CTRL, ctrls[i]);
			bus_wr(RSTX_ADDR_TXDATA, 8'h00);
			edge_gap(g);
			chk(80'(g), 80'(gaps[i]));
		end
		wait_idle();
		chk(80'(irq_n), 80'h7);
		print_verdict();
	end
endmodule : radio_serial_transmit_path_tb
